// ===== logic/ppw_pkg.sv
package ppw_pkg;

    // mode register field layout
    localparam int unsigned MODE_WIDTH = 16;
    localparam int unsigned WAIT_LSB = 0;
    localparam int unsigned WAIT_MSB = 1;
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [MODE_WIDTH-1:0] MODE_RESET = 16'h0000;

    // status register field layout
    localparam int unsigned STAT_WIDTH = 16;
    localparam int unsigned UNDERFLOW_BIT = 6;
    localparam logic [STAT_WIDTH-1:0] STAT_RESET = 16'h0000;

    // buffer geometry
    localparam int unsigned BUF_COUNT = 4;
    localparam int unsigned DATA_WIDTH = 8;
    localparam logic [1:0] IDX_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] CNT_RESET = 2'h0;

    typedef enum logic [2:0] {
        PPW_IDLE = 3'b001,
        PPW_XFER = 3'b010,
        PPW_WAIT = 3'b100
    } ppw_state_e;

    // one master-mode request from the core
    typedef struct packed {
        logic valid;
        logic is_read;
        logic [DATA_WIDTH-1:0] wdata;
    } ppw_req_s;

    // one external read strobe in slave buffer mode
    typedef struct packed {
        logic strobe;
        logic [1:0] index;
    } ppw_slave_rd_s;

endpackage

// ===== logic/ppw_port.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // configuration
    input wire logic mode_we_i,
    input wire logic [ppw_pkg::MODE_WIDTH-1:0] mode_wdata_i,
    output logic [ppw_pkg::MODE_WIDTH-1:0] mode_o,
    // status
    input wire logic underflow_clr_i,
    output logic [ppw_pkg::STAT_WIDTH-1:0] status_o,
    // master-mode requests
    input wire ppw_pkg::ppw_req_s req_i,
    output logic req_ready_o,
    output logic bus_strobe_o,
    output logic bus_read_o,
    output logic [ppw_pkg::DATA_WIDTH-1:0] bus_wdata_o,
    output logic done_o,
    // slave buffer refill from software
    input wire logic buf_we_i,
    input wire logic [1:0] buf_idx_i,
    input wire logic [ppw_pkg::DATA_WIDTH-1:0] buf_wdata_i,
    // external slave reads
    input wire ppw_pkg::ppw_slave_rd_s slave_rd_i,
    output logic [ppw_pkg::DATA_WIDTH-1:0] slave_rdata_o
);

    ////////////////////////////////////////////////////////////////////////////
    // mode register
    logic [ppw_pkg::MODE_WIDTH-1:0] mode_q, mode_d;

    always_comb begin
        mode_d = mode_q;
        if (mode_we_i) begin
            mode_d = mode_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= ppw_pkg::MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign mode_o = mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // buffer storage, one entry per slot
    logic [ppw_pkg::DATA_WIDTH-1:0] buf_q [ppw_pkg::BUF_COUNT];
    logic [ppw_pkg::DATA_WIDTH-1:0] buf_d [ppw_pkg::BUF_COUNT];

    for (genvar g = 0; g < ppw_pkg::BUF_COUNT; g++) begin : g_buf
        always_comb begin
            buf_d[g] = buf_q[g];
            if (buf_we_i && buf_idx_i == 2'(g)) begin
                buf_d[g] = buf_wdata_i;
            end
        end

        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                buf_q[g] <= ppw_pkg::DATA_RESET;
            end else begin
                buf_q[g] <= buf_d[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot occupancy and slave read data
    logic [ppw_pkg::BUF_COUNT-1:0] full_q, full_d;
    logic [ppw_pkg::DATA_WIDTH-1:0] rdata_q, rdata_d;
    logic read_empty;

    always_comb begin
        rdata_d = rdata_q;
        full_d = full_q;
        read_empty = 1'b0;
        if (slave_rd_i.strobe) begin
            rdata_d = buf_q[slave_rd_i.index];
            full_d[slave_rd_i.index] = 1'b0;
            read_empty = !full_q[slave_rd_i.index];
        end
        // a refill landing with a read of the same slot leaves it full
        if (buf_we_i) begin
            full_d[buf_idx_i] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            full_q <= '0;
            rdata_q <= ppw_pkg::DATA_RESET;
        end else begin
            full_q <= full_d;
            rdata_q <= rdata_d;
        end
    end

    assign slave_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // underflow flag
    logic underflow_q, underflow_d;

    always_comb begin
        underflow_d = underflow_q;
        if (underflow_clr_i) begin
            underflow_d = 1'b0;
        end
        // hardware set comes last so it beats a software clear in the same cycle
        if (read_empty) begin
            underflow_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            underflow_q <= 1'b0;
        end else begin
            underflow_q <= underflow_d;
        end
    end

    always_comb begin
        status_o = ppw_pkg::STAT_RESET;
        status_o[ppw_pkg::UNDERFLOW_BIT] = underflow_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // master transfer sequencer
    ppw_pkg::ppw_state_e state_q, state_d;
    logic [1:0] wait_q, wait_d;
    logic read_q, read_d;
    logic [ppw_pkg::DATA_WIDTH-1:0] wdata_q, wdata_d;
    logic done_q, done_d;
    logic [1:0] wait_code;
    logic [1:0] wait_eff;

    assign wait_code = mode_q[ppw_pkg::WAIT_MSB:ppw_pkg::WAIT_LSB];

    always_comb begin
        // reads lose the single-clock code; writes keep every code
        if (read_q && wait_code == ppw_pkg::WAIT_ONE) begin
            wait_eff = ppw_pkg::WAIT_NONE;
        end else begin
            wait_eff = wait_code;
        end
    end

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        read_d = read_q;
        wdata_d = wdata_q;
        done_d = 1'b0;
        case (state_q)
            ppw_pkg::PPW_IDLE: begin
                if (req_i.valid) begin
                    read_d = req_i.is_read;
                    wdata_d = req_i.wdata;
                    state_d = ppw_pkg::PPW_XFER;
                end
            end
            ppw_pkg::PPW_XFER: begin
                if (wait_eff == ppw_pkg::WAIT_NONE) begin
                    done_d = 1'b1;
                    state_d = ppw_pkg::PPW_IDLE;
                end else begin
                    wait_d = wait_eff;
                    state_d = ppw_pkg::PPW_WAIT;
                end
            end
            ppw_pkg::PPW_WAIT: begin
                wait_d = wait_q - 2'h1;
                if (wait_q == 2'h1) begin
                    done_d = 1'b1;
                    state_d = ppw_pkg::PPW_IDLE;
                end
            end
            default: begin
                state_d = ppw_pkg::PPW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ppw_pkg::PPW_IDLE;
            wait_q <= ppw_pkg::CNT_RESET;
            read_q <= 1'b0;
            wdata_q <= ppw_pkg::DATA_RESET;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            read_q <= read_d;
            wdata_q <= wdata_d;
            done_q <= done_d;
        end
    end

    // ready returns in the cycle of done, so a new request may follow at once
    assign req_ready_o = (state_q == ppw_pkg::PPW_IDLE);
    assign bus_strobe_o = (state_q == ppw_pkg::PPW_XFER);
    assign bus_read_o = read_q;
    assign bus_wdata_o = wdata_q;
    assign done_o = done_q;

endmodule // ppw_port
`default_nettype wire

// ===== test/ppw_props_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_props (
    // watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic underflow_clr_i,
    input wire logic [15:0] status_o,
    input wire ppw_pkg::ppw_slave_rd_s slave_rd_i,
    input wire logic bus_strobe_o,
    input wire logic bus_read_o,
    input wire logic done_o,
    input wire logic [15:0] mode_o
);
    wire logic wr = bus_strobe_o && !bus_read_o;
    wire logic rd = bus_strobe_o && bus_read_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wr_wait_none_a: assert property (wr && mode_o[1:0] == 2'h0 |=> done_o)
        else $error("write wait 0");
    wr_wait_three_a: assert property (wr && mode_o[1:0] == 2'h3 |=> !done_o [*3] ##1 done_o)
        else $error("write wait 3");
    rd_wait_one_a: assert property (rd && mode_o[1:0] == 2'h1 |=> done_o)
        else $error("read wait 1");
    rd_wait_two_a: assert property (rd && mode_o[1:0] == 2'h2 |=> !done_o [*2] ##1 done_o)
        else $error("read wait 2");
    underflow_hold_a: assert property (status_o[6] && !underflow_clr_i |=> status_o[6])
        else $error("underflow lost");
    underflow_clear_a: assert property (underflow_clr_i && !slave_rd_i.strobe |=> !status_o[6])
        else $error("underflow kept");
endmodule // ppw_props
bind ppw_port ppw_props ppw_props_i (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .underflow_clr_i(underflow_clr_i),
    .status_o(status_o),
    .slave_rd_i(slave_rd_i),
    .bus_strobe_o(bus_strobe_o),
    .bus_read_o(bus_read_o),
    .done_o(done_o),
    .mode_o(mode_o)
);
`default_nettype wire

// ===== test/ppw_ext_master.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_ext_master (
    // control
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic go_i,
    input wire logic [1:0] idx_i,
    input wire logic underflow_i,
    // read strobe
    output var ppw_pkg::ppw_slave_rd_s rd_o
);
    always_ff @(posedge clk_i) begin
        rd_o.strobe <= !reset_i && go_i && !underflow_i;
        rd_o.index <= idx_i;
    end
endmodule // ppw_ext_master
`default_nettype wire

// ===== test/test_parallel_port_wait_and_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module test_parallel_port_wait_and_buffer;
    logic clk_i = 0, reset_i = 1, mwe = 0, clr = 0, bwe = 0, go = 0, rdo, done, rdy;
    logic [15:0] mwd = '0, mode, stat;
    logic [1:0] bidx = '0, gidx = '0;
    logic [7:0] bwd = '0, d, wdo, rdata;
    ppw_pkg::ppw_req_s req = '0;
    ppw_pkg::ppw_slave_rd_s srd;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    initial forever #4 clk_i = ~clk_i;
    ppw_port ppw_port_i (.clk_i(clk_i), .reset_i(reset_i), .mode_we_i(mwe),
        .mode_wdata_i(mwd), .mode_o(mode), .underflow_clr_i(clr), .status_o(stat),
        .req_i(req), .req_ready_o(rdy), .bus_strobe_o(), .bus_read_o(rdo),
        .bus_wdata_o(wdo), .done_o(done), .buf_we_i(bwe), .buf_idx_i(bidx),
        .buf_wdata_i(bwd), .slave_rd_i(srd), .slave_rdata_o(rdata));
    ppw_ext_master ppw_ext_master_i (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
        .idx_i(gidx), .underflow_i(stat[6]), .rd_o(srd));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] exp_n(input logic r, input logic [1:0] c);
        return (r && c == 2'h1) ? 16'h0001 : 16'h0001 + 16'(c);
    endfunction
    task xfer(input logic r, input logic [1:0] c);
        int n;
        d = 8'($urandom);
        @(posedge clk_i);
        mwe <= 1'b1;
        mwd <= {14'($urandom), c};
        @(posedge clk_i);
        mwe <= 1'b0;
        req <= '{valid: 1'b1, is_read: r, wdata: d};
        @(posedge clk_i);
        req.valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (done !== 1'b1 && n < 9);
        check(16'(n), exp_n(r, c));
        check({mode[1:0], rdo, rdy, wdo}, {c, r, 1'b1, d});
    endtask
    task sread(input logic [1:0] i);
        @(posedge clk_i);
        go <= 1'b1;
        gidx <= i;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task fill(input logic [1:0] i, input logic [7:0] v);
        @(posedge clk_i);
        bwe <= 1'b1;
        bidx <= i;
        bwd <= v;
        @(posedge clk_i);
        bwe <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out;
        end
    end
    initial begin
        void'($urandom(33354));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int k = 0; k < 8; k++) xfer(k[0], k[2:1]);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            fill(2'(k), d);
            sread(2'(k));
            check({stat[15:8], rdata}, {8'h00, d});
        end
        sread(2'h2);
        check(stat, 16'h0040);
        fill(2'h1, ~d);
        sread(2'h1);
        check(stat, 16'h0040);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        sread(2'h1);
        check({stat[7:0], rdata}, {8'h00, ~d});
        @(posedge clk_i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        #1;
        check(stat, 16'h0040);
        close_out;
    end
endmodule // test_parallel_port_wait_and_buffer
`default_nettype wire
